// >>> logic/ufs_regs.sv
/*
 * UART FIFO status and shadow registers: controller status, FIFO levels,
 * soft reset, request-to-send shadow with auto flow and loopback, and a
 * small interrupt group.
 * Assumes the FIFO push/pop strobes come from logic on CORE_CLK and the
 * serial activity levels may come from another clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ufs_regs #(
	parameter int FIFO_DEPTH = 16,
	parameter bit AUTO_FLOW_OPTION = 1'b1
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [31:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [31:0] RDATA,
	// FIFO occupancy strobes, same clock
	input wire logic TX_PUSH,
	input wire logic TX_POP,
	input wire logic RX_PUSH,
	input wire logic RX_POP,
	// Serial activity levels, may be asynchronous
	input wire logic TX_ACTIVE,
	input wire logic RX_ACTIVE,
	// Controls to the FIFOs and the rest of the controller
	output logic TX_FIFO_FLUSH,
	output logic RX_FIFO_FLUSH,
	output logic CTRL_RST_N,
	// Modem lines
	output logic RTS_N,
	output logic LOOP_RTS,
	// Interrupt
	output logic IRQ
);

	localparam int LW = ufs_pkg::LEVEL_W;
	localparam int NEV = ufs_pkg::NUM_EV;
	localparam logic [LW-1:0] DEPTH = LW'(FIFO_DEPTH);
	localparam logic [LW-1:0] ONE = LW'(1);

	typedef struct packed {
		logic [LW-1:0] tx_lvl;
		logic [LW-1:0] rx_lvl;
		logic rts;
		logic loop;
		logic auto_fc;
		logic fifo_en;
		logic [1:0] trig;
		logic tx_fl;
		logic rx_fl;
		logic [1:0] ur_cnt;
		logic rst_o;
		logic [NEV-1:0] ists;
		logic [NEV-1:0] ien;
		logic [1:0] act_s1;
		logic [1:0] act_s2;
		logic rts_n;
		logic lb_rts;
		logic [31:0] rdata;
	} ufs_st_t;

	ufs_st_t st_r;
	ufs_st_t st_nxt;

	function automatic ufs_st_t rst_val();
		ufs_st_t v;
		v = '0;
		v.tx_lvl = ufs_pkg::LEVEL_RST;
		v.rx_lvl = ufs_pkg::LEVEL_RST;
		v.trig = ufs_pkg::TRIG_RST;
		v.rst_o = 1'b1;
		v.rts_n = ufs_pkg::RTS_N_RST;
		return v;
	endfunction

	// Receive trigger threshold chosen by the FIFO control trigger field
	function automatic logic [LW-1:0] thresh(input logic [1:0] t);
		logic [LW-1:0] v;
		v = ONE;
		unique case (t)
			2'h0: v = ONE;
			2'h1: v = LW'(FIFO_DEPTH / 4);
			2'h2: v = LW'(FIFO_DEPTH / 2);
			2'h3: v = LW'(FIFO_DEPTH - 2);
		endcase
		return v;
	endfunction

	logic wr_sts_clr;
	logic wr_ien;
	logic wr_mcr;
	logic wr_fcr;
	logic wr_srr;
	logic wr_srts;
	logic fl_tx;
	logic fl_rx;
	logic ur_req;
	logic busy;
	logic over_now;
	logic over_nxt;
	logic [NEV-1:0] ev;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.tx_fl = 1'b0;
		st_nxt.rx_fl = 1'b0;
		// First stage feeds only the second stage
		st_nxt.act_s1 = {TX_ACTIVE, RX_ACTIVE};
		st_nxt.act_s2 = st_r.act_s1;

		wr_sts_clr = WR_EN && (ADDR == ufs_pkg::IRQ_CLR_OFS);
		wr_ien = WR_EN && (ADDR == ufs_pkg::IRQ_EN_OFS);
		wr_mcr = WR_EN && (ADDR == ufs_pkg::MODEM_CTRL_OFS);
		wr_fcr = WR_EN && (ADDR == ufs_pkg::FIFO_CTRL_OFS);
		wr_srr = WR_EN && (ADDR == ufs_pkg::SOFT_RESET_OFS);
		wr_srts = WR_EN && (ADDR == ufs_pkg::RTS_SHADOW_OFS);

		// Disabling the FIFOs also empties both of them
		fl_tx = (wr_srr && WDATA[ufs_pkg::SRR_TX_FLUSH])
			|| (wr_fcr && WDATA[ufs_pkg::FCR_TX_FLUSH])
			|| (wr_fcr && st_r.fifo_en && !WDATA[ufs_pkg::FCR_ENABLE]);
		fl_rx = (wr_srr && WDATA[ufs_pkg::SRR_RX_FLUSH])
			|| (wr_fcr && WDATA[ufs_pkg::FCR_RX_FLUSH])
			|| (wr_fcr && st_r.fifo_en && !WDATA[ufs_pkg::FCR_ENABLE]);
		ur_req = wr_srr && WDATA[ufs_pkg::SRR_CTRL];

		// Occupancy: a push into a full FIFO or a pop from an empty one is lost
		if (TX_PUSH && (st_r.tx_lvl != DEPTH) && !(TX_POP && st_r.tx_lvl != '0))
			st_nxt.tx_lvl = st_r.tx_lvl + ONE;
		else if (TX_POP && (st_r.tx_lvl != '0) && !TX_PUSH)
			st_nxt.tx_lvl = st_r.tx_lvl - ONE;
		if (RX_PUSH && (st_r.rx_lvl != DEPTH) && !(RX_POP && st_r.rx_lvl != '0))
			st_nxt.rx_lvl = st_r.rx_lvl + ONE;
		else if (RX_POP && (st_r.rx_lvl != '0) && !RX_PUSH)
			st_nxt.rx_lvl = st_r.rx_lvl - ONE;
		// A flush wins over a push in the same cycle
		if (fl_tx) begin
			st_nxt.tx_lvl = '0;
			st_nxt.tx_fl = 1'b1;
		end
		if (fl_rx) begin
			st_nxt.rx_lvl = '0;
			st_nxt.rx_fl = 1'b1;
		end

		if (wr_mcr) begin
			st_nxt.rts = WDATA[ufs_pkg::MCR_RTS];
			st_nxt.loop = WDATA[ufs_pkg::MCR_LOOP];
			st_nxt.auto_fc = WDATA[ufs_pkg::MCR_AUTO] && AUTO_FLOW_OPTION;
		end
		if (wr_srts)
			st_nxt.rts = WDATA[ufs_pkg::SRTS_RTS];
		if (wr_fcr) begin
			st_nxt.fifo_en = WDATA[ufs_pkg::FCR_ENABLE];
			st_nxt.trig = WDATA[ufs_pkg::FCR_TRIG_LO +: 2];
		end

		over_now = st_r.rx_lvl > thresh(st_r.trig);
		over_nxt = st_nxt.rx_lvl > thresh(st_nxt.trig);
		ev = '0;
		ev[ufs_pkg::EV_TX_EMPTY] = (st_nxt.tx_lvl == '0) && (st_r.tx_lvl != '0);
		ev[ufs_pkg::EV_TX_FULL] = (st_nxt.tx_lvl == DEPTH)
			&& (st_r.tx_lvl != DEPTH);
		ev[ufs_pkg::EV_RX_TRIG] = over_nxt && !over_now;
		// Set beats clear so an event in the clearing cycle is kept
		if (wr_sts_clr)
			st_nxt.ists = st_r.ists & ~WDATA[NEV-1:0];
		st_nxt.ists = st_nxt.ists | ev;
		if (wr_ien)
			st_nxt.ien = WDATA[NEV-1:0];

		// Pin is inactive high in loopback; the bit goes inward instead
		if (st_nxt.loop)
			st_nxt.rts_n = 1'b1;
		else if (st_nxt.auto_fc && st_nxt.fifo_en && over_nxt)
			st_nxt.rts_n = 1'b1;
		else
			st_nxt.rts_n = !st_nxt.rts;
		st_nxt.lb_rts = st_nxt.loop && st_nxt.rts;

		// Busy counts buffered data or a serial activity level once it has
		// passed both sync stages, so activity alone sets it two cycles later
		busy = (|st_r.act_s2) || (st_r.tx_lvl != '0)
			|| (st_r.rx_lvl != '0);

		// Reads only sample state; unmapped and write-only addresses give 0
		st_nxt.rdata = '0;
		if (RD_EN) begin
			unique case (ADDR)
				ufs_pkg::CTRL_STATUS_OFS: begin
					st_nxt.rdata[ufs_pkg::STS_BUSY] = busy;
					st_nxt.rdata[ufs_pkg::STS_TX_ROOM] =
						st_r.tx_lvl != DEPTH;
					st_nxt.rdata[ufs_pkg::STS_TX_EMPTY] =
						st_r.tx_lvl == '0;
				end
				ufs_pkg::TX_LEVEL_OFS:
					st_nxt.rdata[LW-1:0] = st_r.tx_lvl;
				ufs_pkg::RX_LEVEL_OFS:
					st_nxt.rdata[LW-1:0] = st_r.rx_lvl;
				ufs_pkg::RTS_SHADOW_OFS:
					st_nxt.rdata[ufs_pkg::SRTS_RTS] = st_r.rts;
				ufs_pkg::MODEM_CTRL_OFS: begin
					st_nxt.rdata[ufs_pkg::MCR_RTS] = st_r.rts;
					st_nxt.rdata[ufs_pkg::MCR_LOOP] = st_r.loop;
					st_nxt.rdata[ufs_pkg::MCR_AUTO] = st_r.auto_fc;
				end
				ufs_pkg::FIFO_CTRL_OFS: begin
					st_nxt.rdata[ufs_pkg::FCR_ENABLE] = st_r.fifo_en;
					st_nxt.rdata[ufs_pkg::FCR_TRIG_LO +: 2] = st_r.trig;
				end
				ufs_pkg::IRQ_STS_OFS:
					st_nxt.rdata[NEV-1:0] = st_r.ists;
				ufs_pkg::IRQ_EN_OFS:
					st_nxt.rdata[NEV-1:0] = st_r.ien;
				default: st_nxt.rdata = '0;
			endcase
		end

		// Controller reset: all state but the first sync stage to defaults, held for a fixed count
		// and then released on a clock edge
		if (ur_req) begin
			st_nxt = rst_val();
			st_nxt.act_s1 = {TX_ACTIVE, RX_ACTIVE};
			st_nxt.ur_cnt = ufs_pkg::SOFT_RST_HOLD;
			st_nxt.rst_o = 1'b0;
		end else if (st_r.ur_cnt != 2'h0) begin
			st_nxt = rst_val();
			st_nxt.act_s1 = {TX_ACTIVE, RX_ACTIVE};
			st_nxt.ur_cnt = st_r.ur_cnt - 2'h1;
			st_nxt.rst_o = (st_r.ur_cnt == 2'h1);
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			st_r <= rst_val();
		else
			st_r <= st_nxt;
	end

	assign RDATA = st_r.rdata;
	assign TX_FIFO_FLUSH = st_r.tx_fl;
	assign RX_FIFO_FLUSH = st_r.rx_fl;
	assign CTRL_RST_N = st_r.rst_o;
	assign RTS_N = st_r.rts_n;
	assign LOOP_RTS = st_r.lb_rts;
	assign IRQ = |(st_r.ists & st_r.ien);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	property p_tx_room;
		RD_EN && ADDR == ufs_pkg::CTRL_STATUS_OFS |=>
			RDATA[ufs_pkg::STS_TX_ROOM] == ($past(st_r.tx_lvl) != DEPTH);
	endproperty
	a_tx_room: assert property (p_tx_room) else $error("tx room bit wrong");

	property p_busy;
		RD_EN && ADDR == ufs_pkg::CTRL_STATUS_OFS
			&& st_r.act_s2 == 2'h0 && st_r.tx_lvl == '0
			&& st_r.rx_lvl == '0 |=> !RDATA[ufs_pkg::STS_BUSY];
	endproperty
	a_busy: assert property (p_busy) else $error("busy set while idle");

	property p_busy_sync;
		$rose(TX_ACTIVE) && st_r.ur_cnt == 2'h0 && !ur_req
			##0 (TX_ACTIVE && !ur_req && st_r.ur_cnt == 2'h0) [*3]
			|-> st_r.act_s2[1];
	endproperty
	a_busy_sync: assert property (p_busy_sync) else $error("busy sync late");

	property p_tx_level;
		RD_EN && ADDR == ufs_pkg::TX_LEVEL_OFS |=>
			RDATA == {27'h0, $past(st_r.tx_lvl)};
	endproperty
	a_tx_level: assert property (p_tx_level) else $error("tx level wrong");

	property p_rx_level;
		RD_EN && ADDR == ufs_pkg::RX_LEVEL_OFS |=>
			RDATA == {27'h0, $past(st_r.rx_lvl)};
	endproperty
	a_rx_level: assert property (p_rx_level) else $error("rx level wrong");

	property p_tx_flush;
		WR_EN && ADDR == ufs_pkg::SOFT_RESET_OFS
			&& WDATA[ufs_pkg::SRR_TX_FLUSH] && !WDATA[ufs_pkg::SRR_CTRL]
			&& st_r.ur_cnt == 2'h0
			|=> TX_FIFO_FLUSH && st_r.tx_lvl == '0 ##1 !TX_FIFO_FLUSH;
	endproperty
	a_tx_flush: assert property (p_tx_flush) else $error("tx flush");

	property p_rx_flush;
		WR_EN && ADDR == ufs_pkg::FIFO_CTRL_OFS
			&& WDATA[ufs_pkg::FCR_RX_FLUSH] && st_r.ur_cnt == 2'h0
			|=> RX_FIFO_FLUSH && st_r.rx_lvl == '0 ##1 !RX_FIFO_FLUSH;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("rx flush");

	property p_ctrl_rst;
		ur_req |=> !CTRL_RST_N [*2] ##1 CTRL_RST_N;
	endproperty
	a_ctrl_rst: assert property (p_ctrl_rst) else $error("soft reset");

	property p_shadow;
		WR_EN && ADDR == ufs_pkg::RTS_SHADOW_OFS && st_r.ur_cnt == 2'h0
			##1 RD_EN && ADDR == ufs_pkg::MODEM_CTRL_OFS
			|=> RDATA[ufs_pkg::MCR_RTS] == $past(WDATA[0], 2);
	endproperty
	a_shadow: assert property (p_shadow) else $error("shadow mismatch");

	property p_rts_plain;
		!st_r.loop && !st_r.auto_fc |-> RTS_N == !st_r.rts;
	endproperty
	a_rts_plain: assert property (p_rts_plain) else $error("rts pin");

	property p_rts_auto;
		st_r.auto_fc && st_r.fifo_en
			&& st_r.rx_lvl > thresh(st_r.trig) |-> RTS_N;
	endproperty
	a_rts_auto: assert property (p_rts_auto) else $error("rts auto");

	property p_loop;
		st_r.loop |-> RTS_N && LOOP_RTS == st_r.rts;
	endproperty
	a_loop: assert property (p_loop) else $error("loopback rts");

	property p_tx_empty;
		RD_EN && ADDR == ufs_pkg::CTRL_STATUS_OFS |=>
			RDATA[ufs_pkg::STS_TX_EMPTY] == ($past(st_r.tx_lvl) == '0)
			&& RDATA[31:3] == 29'h0;
	endproperty
	a_tx_empty: assert property (p_tx_empty) else $error("tx empty bit");

	c_full: cover property (st_r.tx_lvl == DEPTH);
	c_flush: cover property (TX_FIFO_FLUSH ##1 RX_FIFO_FLUSH);
	c_auto: cover property (st_r.auto_fc && st_r.fifo_en && $rose(RTS_N));
	c_soft: cover property ($fell(CTRL_RST_N));

endmodule // ufs_regs

`default_nettype wire

// >>> logic/ufs_pkg.sv
/*
 * Constants for the UART FIFO status and shadow register block: byte
 * addresses, field positions, reset values and timing counts.
 * Assumes a 32-bit byte address and a 32-bit data word on the register port.
 */
package ufs_pkg;

	// ****************************************************************
	// Register byte addresses
	// ****************************************************************
	localparam logic [31:0] IRQ_STS_OFS = 32'h5000_1060;
	localparam logic [31:0] IRQ_CLR_OFS = 32'h5000_1064;
	localparam logic [31:0] IRQ_EN_OFS = 32'h5000_1068;
	localparam logic [31:0] MODEM_CTRL_OFS = 32'h5000_1070;
	localparam logic [31:0] FIFO_CTRL_OFS = 32'h5000_1074;
	localparam logic [31:0] CTRL_STATUS_OFS = 32'h5000_107c;
	localparam logic [31:0] TX_LEVEL_OFS = 32'h5000_1080;
	localparam logic [31:0] RX_LEVEL_OFS = 32'h5000_1084;
	localparam logic [31:0] SOFT_RESET_OFS = 32'h5000_1088;
	localparam logic [31:0] RTS_SHADOW_OFS = 32'h5000_108c;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int STS_BUSY = 0;
	localparam int STS_TX_ROOM = 1;
	localparam int STS_TX_EMPTY = 2;
	localparam int SRR_CTRL = 0;
	localparam int SRR_RX_FLUSH = 1;
	localparam int SRR_TX_FLUSH = 2;
	localparam int SRTS_RTS = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_LOOP = 4;
	localparam int MCR_AUTO = 5;
	localparam int FCR_ENABLE = 0;
	localparam int FCR_RX_FLUSH = 1;
	localparam int FCR_TX_FLUSH = 2;
	localparam int FCR_TRIG_LO = 6;
	localparam int EV_TX_EMPTY = 0;
	localparam int EV_TX_FULL = 1;
	localparam int EV_RX_TRIG = 2;
	localparam int NUM_EV = 3;
	localparam int LEVEL_W = 5;

	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [LEVEL_W-1:0] LEVEL_RST = 5'h00;
	localparam logic RTS_N_RST = 1'b1;
	localparam logic [1:0] TRIG_RST = 2'h0;
	localparam logic [1:0] SOFT_RST_HOLD = 2'h2;

endpackage : ufs_pkg

// >>> dv/ufs_far_end.sv
/*
 * Far-end model: a remote sender that loads the receive FIFO one entry a
 * cycle while the bench asks it to send, and holds off while the
 * request-to-send pin is high.
 * Assumes the same clock as the block and the pin registered by the block.
 */
`timescale 1ns/1ps
`default_nettype none

module ufs_far_end (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin from the block and go signal from the bench
	input wire logic rts_n,
	input wire logic send,
	// Receive FIFO side
	output logic rx_push,
	output logic rx_active
);
	typedef struct packed {
		logic push;
		logic active;
	} ufs_far_t;
	ufs_far_t st_r;
	ufs_far_t st_nxt;

	// A real sender honours the pin, so the stop lags it by one cycle
	always_comb begin
		st_nxt.active = send;
		st_nxt.push = send && !rts_n;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rx_push = st_r.push;
	assign rx_active = st_r.active;
endmodule // ufs_far_end

`default_nettype wire

// >>> dv/ufs_regs_tb.sv
/*
 * Self-checking bench for ufs_regs: register port tasks, FIFO strobes,
 * modem pin checks and a far-end sender on the receive side.
 * Assumes one 100 MHz clock and read data one cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module ufs_regs_tb;
	logic CORE_CLK = 1'b0, RST_N = 1'b0, WR_EN = 1'b0, RD_EN = 1'b0;
	logic [31:0] ADDR = 32'h0, WDATA = 32'h0, RDATA, d;
	logic TX_PUSH = 1'b0, TX_POP = 1'b0, TX_ACTIVE = 1'b0, send = 1'b0;
	logic RX_POP = 1'b0;
	logic RX_PUSH, RX_ACTIVE, TX_FIFO_FLUSH, RX_FIFO_FLUSH;
	logic CTRL_RST_N, RTS_N, LOOP_RTS, IRQ;
	int errors = 0, compares = 0, cycles = 0;

	ufs_regs i_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA),
		.TX_PUSH(TX_PUSH), .TX_POP(TX_POP), .RX_PUSH(RX_PUSH),
		.RX_POP(RX_POP), .TX_ACTIVE(TX_ACTIVE), .RX_ACTIVE(RX_ACTIVE),
		.TX_FIFO_FLUSH(TX_FIFO_FLUSH), .RX_FIFO_FLUSH(RX_FIFO_FLUSH),
		.CTRL_RST_N(CTRL_RST_N), .RTS_N(RTS_N), .LOOP_RTS(LOOP_RTS),
		.IRQ(IRQ));
	ufs_far_end i_far (.clk(CORE_CLK), .rst_n(RST_N), .rts_n(RTS_N),
		.send(send), .rx_push(RX_PUSH), .rx_active(RX_ACTIVE));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic conclude();
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= v;
		WR_EN <= 1'b1;
		@(posedge CORE_CLK);
		WR_EN <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdc(input logic [31:0] a, input logic [31:0] e,
		input string n);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD_EN <= 1'b1;
		@(posedge CORE_CLK);
		RD_EN <= 1'b0;
		#1 d = RDATA;
		chk(n, e, d);
	endtask

	// Write followed by a read with no idle cycle between them
	task automatic wrrd(input logic [31:0] a, input logic [31:0] v,
		input logic [31:0] ra, input logic [31:0] e, input string n);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= v;
		WR_EN <= 1'b1;
		@(posedge CORE_CLK);
		WR_EN <= 1'b0;
		ADDR <= ra;
		RD_EN <= 1'b1;
		@(posedge CORE_CLK);
		RD_EN <= 1'b0;
		#1 d = RDATA;
		chk(n, e, d);
	endtask

	task automatic pop_rx();
		@(posedge CORE_CLK) RX_POP <= 1'b1;
		@(posedge CORE_CLK) RX_POP <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		rdc(ufs_pkg::CTRL_STATUS_OFS, 32'h6, "status");
		rdc(ufs_pkg::TX_LEVEL_OFS, 32'h0, "tx_level");
		rdc(ufs_pkg::RX_LEVEL_OFS, 32'h0, "rx_level");
		rdc(ufs_pkg::RTS_SHADOW_OFS, 32'h0, "shadow");
		rdc(32'h5000_10f0, 32'h0, "unmapped");
		chk("rts_n", 32'h1, RTS_N);
	endtask

	task automatic t_tx();
		// One push beyond full must be dropped
		repeat (17) @(posedge CORE_CLK) TX_PUSH <= 1'b1;
		@(posedge CORE_CLK) TX_PUSH <= 1'b0;
		rdc(ufs_pkg::TX_LEVEL_OFS, 32'h10, "tx_level");
		rdc(ufs_pkg::CTRL_STATUS_OFS, 32'h1, "status");
		rdc(ufs_pkg::CTRL_STATUS_OFS, 32'h1, "status");
		chk("irq", 32'h0, IRQ);
		rdc(ufs_pkg::IRQ_STS_OFS, 32'h2, "irq_sts");
		wr(ufs_pkg::IRQ_EN_OFS, 32'h2);
		tick(1);
		chk("irq", 32'h1, IRQ);
		wr(ufs_pkg::IRQ_CLR_OFS, 32'h2);
		tick(1);
		chk("irq", 32'h0, IRQ);
		@(posedge CORE_CLK) TX_POP <= 1'b1;
		@(posedge CORE_CLK) TX_POP <= 1'b0;
		rdc(ufs_pkg::TX_LEVEL_OFS, 32'hf, "tx_level");
		rdc(ufs_pkg::CTRL_STATUS_OFS, 32'h3, "status");
		wr(ufs_pkg::SOFT_RESET_OFS, 32'h4);
		#1 chk("tx_flush", 32'h1, TX_FIFO_FLUSH);
		tick(1);
		chk("tx_flush", 32'h0, TX_FIFO_FLUSH);
		rdc(ufs_pkg::TX_LEVEL_OFS, 32'h0, "tx_level");
		rdc(ufs_pkg::CTRL_STATUS_OFS, 32'h6, "status");
		rdc(ufs_pkg::SOFT_RESET_OFS, 32'h0, "srr");
		@(posedge CORE_CLK) TX_PUSH <= 1'b1;
		@(posedge CORE_CLK) TX_PUSH <= 1'b0;
		wr(ufs_pkg::FIFO_CTRL_OFS, 32'h4);
		#1 chk("tx_flush", 32'h1, TX_FIFO_FLUSH);
		rdc(ufs_pkg::TX_LEVEL_OFS, 32'h0, "tx_level");
	endtask

	task automatic t_rts();
		wr(ufs_pkg::RTS_SHADOW_OFS, 32'h1);
		tick(2);
		chk("rts_n", 32'h0, RTS_N);
		rdc(ufs_pkg::MODEM_CTRL_OFS, 32'h2, "mcr");
		wr(ufs_pkg::MODEM_CTRL_OFS, 32'h0);
		tick(2);
		chk("rts_n", 32'h1, RTS_N);
		rdc(ufs_pkg::RTS_SHADOW_OFS, 32'h0, "shadow");
		wr(ufs_pkg::MODEM_CTRL_OFS, 32'h12);
		tick(2);
		chk("rts_n", 32'h1, RTS_N);
		chk("loop_rts", 32'h1, LOOP_RTS);
		rdc(ufs_pkg::RTS_SHADOW_OFS, 32'h1, "shadow");
		wrrd(ufs_pkg::RTS_SHADOW_OFS, 32'h0, ufs_pkg::MODEM_CTRL_OFS,
			32'h10, "mcr");
	endtask

	task automatic t_auto();
		wr(ufs_pkg::FIFO_CTRL_OFS, 32'h1);
		wr(ufs_pkg::MODEM_CTRL_OFS, 32'h22);
		tick(2);
		chk("rts_n", 32'h0, RTS_N);
		@(posedge CORE_CLK) send <= 1'b1;
		tick(20);
		chk("rts_n", 32'h1, RTS_N);
		@(posedge CORE_CLK) send <= 1'b0;
		tick(3);
		rdc(ufs_pkg::RX_LEVEL_OFS, 32'h3, "rx_level");
		rdc(ufs_pkg::IRQ_STS_OFS, 32'h5, "irq_sts");
		pop_rx();
		rdc(ufs_pkg::RX_LEVEL_OFS, 32'h2, "rx_level");
		chk("rts_n", 32'h1, RTS_N);
		pop_rx();
		tick(1);
		chk("rts_n", 32'h0, RTS_N);
		// Trigger field one: the pin holds off only once the level passes 4
		wr(ufs_pkg::FIFO_CTRL_OFS, 32'h43);
		#1 chk("rx_flush", 32'h1, RX_FIFO_FLUSH);
		rdc(ufs_pkg::RX_LEVEL_OFS, 32'h0, "rx_level");
		tick(2);
		chk("rts_n", 32'h0, RTS_N);
		@(posedge CORE_CLK) send <= 1'b1;
		tick(5);
		@(posedge CORE_CLK) send <= 1'b0;
		tick(3);
		rdc(ufs_pkg::RX_LEVEL_OFS, 32'h6, "rx_level");
		chk("rts_n", 32'h1, RTS_N);
		wr(ufs_pkg::SOFT_RESET_OFS, 32'h2);
		#1 chk("rx_flush", 32'h1, RX_FIFO_FLUSH);
		rdc(ufs_pkg::RX_LEVEL_OFS, 32'h0, "rx_level");
	endtask

	task automatic t_busy();
		@(posedge CORE_CLK) TX_ACTIVE <= 1'b1;
		tick(3);
		rdc(ufs_pkg::CTRL_STATUS_OFS, 32'h7, "status");
		@(posedge CORE_CLK) TX_ACTIVE <= 1'b0;
		tick(3);
		rdc(ufs_pkg::CTRL_STATUS_OFS, 32'h6, "status");
	endtask

	task automatic t_ctrl();
		wr(ufs_pkg::SOFT_RESET_OFS, 32'h1);
		#1 chk("ctrl_rst_n", 32'h0, CTRL_RST_N);
		tick(1);
		chk("ctrl_rst_n", 32'h0, CTRL_RST_N);
		tick(1);
		chk("ctrl_rst_n", 32'h1, CTRL_RST_N);
		rdc(ufs_pkg::MODEM_CTRL_OFS, 32'h0, "mcr");
		chk("rts_n", 32'h1, RTS_N);
	endtask

	// ****************************************************************
	// Clock, timeout and main sequence
	// ****************************************************************
	initial begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	// The whole run needs well under a thousand cycles
	always @(posedge CORE_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end

	initial begin
		repeat (8) @(posedge CORE_CLK);
		RST_N <= 1'b1;
		t_reset();
		t_tx();
		t_rts();
		t_auto();
		t_busy();
		t_ctrl();
		conclude();
	end
endmodule // ufs_regs_tb

`default_nettype wire
